// >>> tma_consts.vh
// Purpose: shared constants of the dual temperature monitor logic
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef TMA_CONSTS_VH
`define TMA_CONSTS_VH
// register read addresses
`define TMA_RD_LOCAL    8'h00
`define TMA_RD_REMOTE   8'h01
`define TMA_RD_FLAGS    8'h02
`define TMA_RD_SETUP    8'h03
`define TMA_RD_RATE     8'h04
`define TMA_RD_LHI      8'h05
`define TMA_RD_LLO      8'h06
`define TMA_RD_RHI      8'h07
`define TMA_RD_RLO      8'h08
// register write addresses
`define TMA_WR_SETUP    8'h09
`define TMA_WR_RATE     8'h0a
`define TMA_WR_LHI      8'h0b
`define TMA_WR_LLO      8'h0c
`define TMA_WR_RHI      8'h0d
`define TMA_WR_RLO      8'h0e
// shared read/write addresses
`define TMA_RW_LTRIP    8'h19
`define TMA_RW_RTRIP    8'h20
`define TMA_RW_HYST     8'h21
// reset values and unmapped read value
`define TMA_RST_SETUP   8'h00
`define TMA_RST_RATE    8'h08
`define TMA_RST_LIMHI   8'h55
`define TMA_RST_LIMLO   8'h00
`define TMA_RST_TRIP    8'h55
`define TMA_RST_HYST    8'h0a
`define TMA_RST_PTR     8'h00
`define TMA_UNMAPPED    8'hff
// setup fields
`define TMA_SET_MASK    7
`define TMA_SET_TRIP2   5
`define TMA_SET_EXT     2
// flag fields
`define TMA_FLG_LHI     6
`define TMA_FLG_LLO     5
`define TMA_FLG_RHI     4
`define TMA_FLG_RLO     3
`define TMA_FLG_OPEN    2
// conversion timing and result coding
`define TMA_FAST_US     15500
`define TMA_CLK_MHZ     250
`define TMA_CODE_MAX    4'ha
`define TMA_EXT_OFS     10'h040
`define TMA_BIN_MAX     8'h7f
`define TMA_EXT_MAX     8'hff
// bus constants
`define TMA_ARA         7'h0c
`endif

// >>> tma_monitor.v
// Purpose: digital side of a dual channel temperature monitor
// Assumes: SMBus pins and sensor inputs are asynchronous to CLK_I
// Notes:   open-drain pins drive low when their enable is high
// How it works
// - rate read at 04, written at 0A
// - rate code divides period by powers two
// - every period converts local and remote
// - rate resets to 0x08
// - extended range adds 64 degree offset
// - binary mode saturates to 0..127
// - results at 00 and 01, read-only
// - local high limit 05/0B, reset 0x55
// - first write byte loads pointer
// - read returns register at pointer
// - alarm pin low on fault, open drain
// - answer alert response with own address
// - open sensor sampled per conversion, flag
// - alarm maskable, trip never masked
// - alarm above high or at low
// - alert response clears gone alarm
// - trip sets above limit, hysteresis release
// - hysteresis register resets to 10
// - alarm pin may act as trip
`timescale 1ns/1ps
`include "tma_consts.vh"
module tma_monitor #(
  parameter [6:0]  DEV_ADDR  = 7'h2a, // arbitrary
  parameter [31:0] FAST_CYC  = `TMA_FAST_US * `TMA_CLK_MHZ
) (
  input  wire       CLK_I,
  input  wire       RST_N_I,
  input  wire       SCL_I,
  input  wire       SDA_I,
  output wire       SDA_O,
  output wire       SDA_OE_O,
  input  wire [9:0] LOCAL_TEMP_I,
  input  wire [9:0] REMOTE_TEMP_I,
  input  wire       REMOTE_OPEN_I,
  output wire       CONV_START_O,
  output wire       ALARM_N_O,
  output wire       ALARM_OE_O,
  output wire       FAIL_SAFE_TRIP_N_O,
  output wire       FAIL_SAFE_TRIP_OE_O
);
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_ADDR = 3'd1;
  localparam [2:0] S_AACK = 3'd2;
  localparam [2:0] S_WBYT = 3'd3;
  localparam [2:0] S_WACK = 3'd4;
  localparam [2:0] S_RBYT = 3'd5;
  localparam [2:0] S_RACK = 3'd6;
  localparam [2:0] S_RLD  = 3'd7;
  // signed degrees to stored code
  function [7:0] enc;
    input [9:0] t;
    input       ext;
    reg   [9:0] v;
    begin
      v = ext ? t + `TMA_EXT_OFS : t;
      if (v[9])
        enc = 8'h00;
      else if (!ext && v > `TMA_BIN_MAX)
        enc = `TMA_BIN_MAX;
      else if (v > `TMA_EXT_MAX)
        enc = `TMA_EXT_MAX;
      else
        enc = v[7:0];
    end
  endfunction
  // release point of a trip comparator
  function [8:0] rel;
    input [7:0] lim;
    input [7:0] hy;
    begin
      rel = (hy > lim) ? 9'h000 : {1'b0, lim - hy};
    end
  endfunction
  reg        scl_m_r, scl_s_r, scl_d_r;
  reg        sda_m_r, sda_s_r, sda_d_r;
  reg [9:0]  lt_m_r,  lt_s_r;
  reg [9:0]  rt_m_r,  rt_s_r;
  reg        op_m_r,  op_s_r;
  reg [2:0]  st_r;
  reg [3:0]  bit_r;
  reg [7:0]  sh_r;
  reg [7:0]  tx_r;
  reg [1:0]  byte_r;
  reg        rw_r, ara_r, oe_r, ara_done_r;
  reg [7:0]  ptr_r;
  reg [7:0]  setup_r, rate_r, lhi_r, llo_r;
  reg [7:0]  rhi_r, rlo_r, ltrip_r, rtrip_r, hyst_r;
  reg [7:0]  ltemp_r, rtemp_r, flags_r;
  reg        alarm_r, ltrip_on_r, rtrip_on_r;
  reg [31:0] cnt_r;
  reg        conv_r;
  wire       scl_rise, scl_fall, start_c, stop_c;
  wire [3:0] code;
  wire [31:0] period;
  wire       cond, alarm_low, trip_any;
  wire [7:0] lt_enc, rt_enc;
  reg  [7:0] rd_data;
  // two-stage synchronisers on the bus and sensor inputs; RST_N_I is used unsynchronised
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
      lt_m_r  <= 10'h000;
      lt_s_r  <= 10'h000;
      rt_m_r  <= 10'h000;
      rt_s_r  <= 10'h000;
      op_m_r  <= 1'b0;
      op_s_r  <= 1'b0;
    end else begin
      scl_m_r <= SCL_I;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= SDA_I;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
      lt_m_r  <= LOCAL_TEMP_I;
      lt_s_r  <= lt_m_r;
      rt_m_r  <= REMOTE_TEMP_I;
      rt_s_r  <= rt_m_r;
      op_m_r  <= REMOTE_OPEN_I;
      op_s_r  <= op_m_r;
    end
  end
  // edge and framing detection on the synchronised pins
  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign start_c  = scl_s_r & scl_d_r & ~sda_s_r & sda_d_r;
  assign stop_c   = scl_s_r & scl_d_r & sda_s_r & ~sda_d_r;
  // conversion period: fastest period shifted by the divide
  assign code   = (rate_r[3:0] > `TMA_CODE_MAX) ? `TMA_CODE_MAX
                                                : rate_r[3:0];
  assign period = FAST_CYC << (`TMA_CODE_MAX - code);
  // conversion scheduler, one start pulse per period
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cnt_r  <= 32'h0000_0000;
      conv_r <= 1'b0;
    end else if (cnt_r + 32'h1 >= period) begin
      cnt_r  <= 32'h0000_0000;
      conv_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 32'h1;
      conv_r <= 1'b0;
    end
  end
  assign lt_enc = enc(lt_s_r, setup_r[`TMA_SET_EXT]);
  assign rt_enc = enc(rt_s_r, setup_r[`TMA_SET_EXT]);
  // results, flags and trip comparators update at each conversion
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ltemp_r    <= 8'h00;
      rtemp_r    <= 8'h00;
      flags_r    <= 8'h00;
      ltrip_on_r <= 1'b0;
      rtrip_on_r <= 1'b0;
    end else if (conv_r) begin
      ltemp_r <= lt_enc;
      rtemp_r <= rt_enc;
      flags_r <= 8'h00;
      flags_r[`TMA_FLG_LHI]  <= lt_enc > lhi_r;
      flags_r[`TMA_FLG_LLO]  <= lt_enc <= llo_r;
      flags_r[`TMA_FLG_RHI]  <= rt_enc > rhi_r;
      flags_r[`TMA_FLG_RLO]  <= rt_enc <= rlo_r;
      flags_r[`TMA_FLG_OPEN] <= op_s_r;
      if (lt_enc > ltrip_r)
        ltrip_on_r <= 1'b1;
      else if ({1'b0, lt_enc} <= rel(ltrip_r, hyst_r))
        ltrip_on_r <= 1'b0;
      if (rt_enc > rtrip_r)
        rtrip_on_r <= 1'b1;
      else if ({1'b0, rt_enc} <= rel(rtrip_r, hyst_r))
        rtrip_on_r <= 1'b0;
    end
  end
  assign cond = |flags_r[`TMA_FLG_LHI:`TMA_FLG_OPEN];
  // alarm latch: a new conversion fault wins over a service clear
  always @(posedge CLK_I) begin
    if (!RST_N_I)
      alarm_r <= 1'b0;
    else if (cond)
      alarm_r <= 1'b1;
    else if (ara_done_r)
      alarm_r <= 1'b0;
  end
  assign trip_any  = ltrip_on_r | rtrip_on_r;
  // pin either shows the trip or the maskable alarm
  assign alarm_low = setup_r[`TMA_SET_TRIP2] ? trip_any
                   : alarm_r & ~setup_r[`TMA_SET_MASK];
  // read mux at the pointer; write-only addresses read as ones
  always @* begin
    case (ptr_r)
      `TMA_RD_LOCAL:  rd_data = ltemp_r;
      `TMA_RD_REMOTE: rd_data = rtemp_r;
      `TMA_RD_FLAGS:  rd_data = flags_r;
      `TMA_RD_SETUP:  rd_data = setup_r;
      `TMA_RD_RATE:   rd_data = rate_r;
      `TMA_RD_LHI:    rd_data = lhi_r;
      `TMA_RD_LLO:    rd_data = llo_r;
      `TMA_RD_RHI:    rd_data = rhi_r;
      `TMA_RD_RLO:    rd_data = rlo_r;
      `TMA_RW_LTRIP:  rd_data = ltrip_r;
      `TMA_RW_RTRIP:  rd_data = rtrip_r;
      `TMA_RW_HYST:   rd_data = hyst_r;
      default:        rd_data = `TMA_UNMAPPED;
    endcase
  end
  // serial slave: samples on scl rise, drives sda after scl fall
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st_r       <= S_IDLE;
      bit_r      <= 4'h0;
      sh_r       <= 8'h00;
      tx_r       <= 8'h00;
      byte_r     <= 2'd0;
      rw_r       <= 1'b0;
      ara_r      <= 1'b0;
      oe_r       <= 1'b0;
      ara_done_r <= 1'b0;
      ptr_r      <= `TMA_RST_PTR;
      setup_r    <= `TMA_RST_SETUP;
      rate_r     <= `TMA_RST_RATE;
      lhi_r      <= `TMA_RST_LIMHI;
      llo_r      <= `TMA_RST_LIMLO;
      rhi_r      <= `TMA_RST_LIMHI;
      rlo_r      <= `TMA_RST_LIMLO;
      ltrip_r    <= `TMA_RST_TRIP;
      rtrip_r    <= `TMA_RST_TRIP;
      hyst_r     <= `TMA_RST_HYST;
    end else begin
      ara_done_r <= 1'b0;
      if (start_c) begin
        st_r   <= S_ADDR;
        bit_r  <= 4'h0;
        byte_r <= 2'd0;
        oe_r   <= 1'b0;
      end else if (stop_c) begin
        st_r <= S_IDLE;
        oe_r <= 1'b0;
      end else if (scl_rise) begin
        case (st_r)
          S_ADDR, S_WBYT: begin
            sh_r  <= {sh_r[6:0], sda_s_r};
            bit_r <= bit_r + 4'h1;
          end
          S_RACK: begin
            ara_done_r <= ara_r;
            st_r       <= (sda_s_r || ara_r) ? S_IDLE : S_RLD;
          end
          default: st_r <= st_r;
        endcase
      end else if (scl_fall) begin
        case (st_r)
          S_ADDR: if (bit_r == 4'h8) begin
            rw_r  <= sh_r[0];
            ara_r <= sh_r[7:1] == `TMA_ARA;
            if (sh_r[7:1] == DEV_ADDR ||
                (sh_r[7:1] == `TMA_ARA && sh_r[0] && alarm_low)) begin
              oe_r <= 1'b1;
              st_r <= S_AACK;
            end else
              st_r <= S_IDLE;
          end
          S_AACK, S_RLD: begin
            bit_r <= 4'h0;
            if (rw_r) begin
              tx_r <= ara_r ? {DEV_ADDR, 1'b1} : rd_data;
              oe_r <= ara_r ? ~DEV_ADDR[6] : ~rd_data[7];
              st_r <= S_RBYT;
            end else begin
              oe_r <= 1'b0;
              st_r <= S_WBYT;
            end
          end
          S_WBYT: if (bit_r == 4'h8) begin
            oe_r <= 1'b1;
            st_r <= S_WACK;
            if (byte_r != 2'd2)
              byte_r <= byte_r + 2'd1;
            if (byte_r == 2'd0)
              ptr_r <= sh_r;
            else if (byte_r == 2'd1) begin
              case (ptr_r)
                `TMA_WR_SETUP: setup_r <= sh_r;
                `TMA_WR_RATE:  rate_r  <= sh_r;
                `TMA_WR_LHI:   lhi_r   <= sh_r;
                `TMA_WR_LLO:   llo_r   <= sh_r;
                `TMA_WR_RHI:   rhi_r   <= sh_r;
                `TMA_WR_RLO:   rlo_r   <= sh_r;
                `TMA_RW_LTRIP: ltrip_r <= sh_r;
                `TMA_RW_RTRIP: rtrip_r <= sh_r;
                `TMA_RW_HYST:  hyst_r  <= sh_r;
                default:       ptr_r   <= ptr_r;
              endcase
            end
          end
          S_WACK: begin
            oe_r  <= 1'b0;
            bit_r <= 4'h0;
            st_r  <= S_WBYT;
          end
          S_RBYT: begin
            if (bit_r == 4'h7) begin
              oe_r <= 1'b0; // master acks
              st_r <= S_RACK;
            end else begin
              bit_r <= bit_r + 4'h1;
              tx_r  <= {tx_r[6:0], 1'b0};
              oe_r  <= ~tx_r[6];
            end
          end
          default: st_r <= st_r;
        endcase
      end
    end
  end
  // open-drain pins only ever pull low
  assign SDA_O               = 1'b0;
  assign SDA_OE_O            = oe_r;
  assign CONV_START_O        = conv_r;
  assign ALARM_N_O           = 1'b0;
  assign ALARM_OE_O          = alarm_low;
  assign FAIL_SAFE_TRIP_N_O  = 1'b0;
  assign FAIL_SAFE_TRIP_OE_O = trip_any;
endmodule // tma_monitor

// >>> tma_monitor_properties.sv
// Purpose: port assertions for the monitor
// Assumes: one clock, synchronous reset
// Notes:   bound below to every monitor
`timescale 1ns/1ps
module tma_monitor_props (
  input wire CLK_I,
  input wire RST_N_I,
  input wire SCL_I,
  input wire SDA_OE_O,
  input wire CONV_START_O,
  input wire ALARM_OE_O,
  input wire FAIL_SAFE_TRIP_OE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // pins leave reset released
  AST_RST_QUIET: assert property ($rose(RST_N_I) |-> !(SDA_OE_O | ALARM_OE_O | CONV_START_O))
    else $error("pin active after reset");
  // start is a lone pulse; the fastest period is far above 8
  AST_CONV_PULSE: assert property (CONV_START_O |=> !CONV_START_O)
    else $error("start pulse too long");
  AST_CONV_GAP: assert property (CONV_START_O |=> !CONV_START_O [*8])
    else $error("start period too short");
  // trip only moves after a conversion, never on bus traffic
  AST_TRIP_RISE: assert property ($rose(FAIL_SAFE_TRIP_OE_O) |-> $past(CONV_START_O))
    else $error("trip set off conversion");
  AST_TRIP_FALL: assert property ($fell(FAIL_SAFE_TRIP_OE_O) |-> $past(CONV_START_O))
    else $error("trip cleared off conversion");
  // data moves only while the bus clock is low
  AST_SDA_SCL_LOW: assert property ($changed(SDA_OE_O) |-> !$past(SCL_I, 2))
    else $error("sda moved with scl high");
  AST_SDA_HELD: assert property ($rose(SCL_I) |=> $stable(SDA_OE_O) [*8])
    else $error("sda moved after scl rise");
  AST_ACK_HOLD: assert property ($rose(SDA_OE_O) |=> SDA_OE_O [*8])
    else $error("driven bit too short");
  CVR_ALARM: cover property ($rose(ALARM_OE_O));
  CVR_TRIP: cover property ($fell(FAIL_SAFE_TRIP_OE_O));
  CVR_ACK: cover property ($rose(SDA_OE_O));
endmodule // tma_monitor_props
bind tma_monitor tma_monitor_props tma_monitor_props_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .SCL_I(SCL_I),
  .SDA_OE_O(SDA_OE_O), .CONV_START_O(CONV_START_O), .ALARM_OE_O(ALARM_OE_O),
  .FAIL_SAFE_TRIP_OE_O(FAIL_SAFE_TRIP_OE_O));

// >>> tma_host_model.sv
// Purpose: bus host model
// Assumes: sda_i is the wired level with pull-up
// Notes:   160 ns bus clock, scl stands high between frames
`timescale 1ns/1ps
module tma_host_model (
  input  wire       clk_i,
  input  wire       sda_i,
  output reg        scl_o,
  output reg        sda_o
);
  reg  [7:0] rx_r;
  reg        bit_r;
  // idle bus
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // quarter bus period
  task qw;
    repeat (10) @(posedge clk_i);
  endtask
  // data set while scl is low, sampled mid high
  task sbit(input b);
    begin
      sda_o <= b;
      qw;
      scl_o <= 1'b1;
      qw;
      bit_r = sda_i;
      qw;
      scl_o <= 1'b0;
      qw;
    end
  endtask
  // msb first, then the ninth bit
  task xbyte(input [7:0] d, input a);
    integer j;
    begin
      for (j = 7; j >= 0; j = j - 1) begin
        sbit(d[j]);
        rx_r = {rx_r[6:0], bit_r};
      end
      sbit(a);
    end
  endtask
  // start also serves as repeated start
  task start;
    begin
      sda_o <= 1'b1;
      qw;
      scl_o <= 1'b1;
      qw;
      sda_o <= 1'b0;
      qw;
      scl_o <= 1'b0;
      qw;
    end
  endtask
  task stop;
    begin
      sda_o <= 1'b0;
      qw;
      scl_o <= 1'b1;
      qw;
      sda_o <= 1'b1;
      qw;
    end
  endtask
  // pointer byte first, data byte only if n
  task wr_tr(input [6:0] a, input [7:0] p, input [7:0] d, input n);
    begin
      start;
      xbyte({a, 1'b0}, 1'b1);
      xbyte(p, 1'b1);
      if (n)
        xbyte(d, 1'b1);
      stop;
    end
  endtask
  // one byte at the pointer, ended by nack
  task rd_tr(input [6:0] a, output [7:0] v, output k);
    begin
      start;
      xbyte({a, 1'b1}, 1'b1);
      k = bit_r;
      xbyte(8'hff, 1'b1);
      v = rx_r;
      stop;
    end
  endtask
endmodule // tma_host_model

// >>> tb.sv
// Purpose: self-checking bench for the monitor
// Assumes: host model drives the bus
// Notes:   64-cycle fast period keeps the run short
`timescale 1ns/1ps
module tb;
  localparam [6:0] DEV = 7'h2a; // arbitrary address
  reg        clk_i = 1'b0;
  reg        rst_n_i = 1'b0;
  reg  [9:0] lt = 10'h019;
  reg  [9:0] rt = 10'h019;
  reg        op = 1'b0;
  reg  [7:0] v;
  reg        k;
  integer    num_errors = 0;
  integer    num_checks = 0;
  integer    cyc = 0;
  integer    gap = 0;
  wire       scl, sda_h, sda_oe, conv, alm_oe, trip_oe;
  wire       sda_lv, alm_lv, trip_lv;
  wire       sda = sda_h & ~(sda_oe & ~sda_lv); // pulled up, open drain
  // 250 MHz
  always #2 clk_i = ~clk_i;
  tma_monitor #(.DEV_ADDR(DEV), .FAST_CYC(32'h40)) tma_monitor_inst (.CLK_I(clk_i), .RST_N_I(rst_n_i),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_lv), .SDA_OE_O(sda_oe), .LOCAL_TEMP_I(lt), .REMOTE_TEMP_I(rt),
    .REMOTE_OPEN_I(op), .CONV_START_O(conv), .ALARM_N_O(alm_lv), .ALARM_OE_O(alm_oe),
    .FAIL_SAFE_TRIP_N_O(trip_lv),
    .FAIL_SAFE_TRIP_OE_O(trip_oe));
  tma_host_model tma_host_model_inst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_h));
  task test_done;
    begin
      if (num_errors == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [95:0] n, input [15:0] g, input [15:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("BAD %0s exp %h seen %h", n, e, g);
      end
    end
  endtask
  // pointer ff means keep the pointer as it is
  task rchk(input [95:0] n, input [7:0] p, input [7:0] e);
    begin
      if (p != 8'hff)
        tma_host_model_inst.wr_tr(DEV, p, 8'h00, 1'b0);
      tma_host_model_inst.rd_tr(DEV, v, k);
      chk(n, v, e);
    end
  endtask
  task wreg(input [7:0] p, input [7:0] d);
    tma_host_model_inst.wr_tr(DEV, p, d, 1'b1);
  endtask
  task ara;
    tma_host_model_inst.rd_tr(7'h0c, v, k);
  endtask
  // cycles up to the next start pulse, bounded
  task waitc;
    begin
      gap = 1;
      @(posedge clk_i);
      while (conv !== 1'b1 && gap < 600) begin
        gap = gap + 1;
        @(posedge clk_i);
      end
      if (gap == 600)
        num_errors = num_errors + 1;
    end
  endtask
  task per(input [7:0] c, input [15:0] e);
    begin
      wreg(8'h0a, c);
      waitc;
      waitc;
      chk("period", gap, e);
    end
  endtask
  // two starts so the synced inputs are surely converted
  task temps(input [9:0] l, input [9:0] r, input o);
    begin
      lt <= l;
      rt <= r;
      op <= o;
      waitc;
      waitc;
      repeat (4) @(posedge clk_i);
    end
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      num_errors = num_errors + 1;
      test_done;
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    waitc;
    waitc;
    chk("rst_period", gap, 16'h100);
    chk("pin_levels", {sda_lv, alm_lv, trip_lv}, 16'h0);
    rchk("rate_rst", 8'h04, 8'h08);
    rchk("lhi_rst", 8'h05, 8'h55);
    rchk("hyst_rst", 8'h21, 8'h0a);
    rchk("local", 8'h00, 8'h19);
    wreg(8'h00, 8'h33);
    rchk("local_ro", 8'h00, 8'h19);
    wreg(8'h0b, 8'h52);
    rchk("lhi_wr", 8'h05, 8'h52);
    rchk("ptr_keep", 8'hff, 8'h52);
    per(8'h0a, 16'h40);
    per(8'h0f, 16'h40);
    per(8'h09, 16'h80);
    rchk("rate_rd", 8'h04, 8'h09);
    temps(10'h3c9, 10'h019, 1'b0);
    rchk("neg_sat", 8'h00, 8'h00);
    rchk("flag_low", 8'h02, 8'h20);
    chk("alm_low", alm_oe, 16'h1);
    temps(10'h096, 10'h019, 1'b0);
    rchk("pos_sat", 8'h00, 8'h7f);
    chk("trip_on", trip_oe, 16'h1);
    ara;
    chk("ara_id", v, 16'h55);
    chk("alm_kept", alm_oe, 16'h1);
    temps(10'h050, 10'h019, 1'b0);
    chk("trip_hys", trip_oe, 16'h1);
    temps(10'h04b, 10'h019, 1'b0);
    chk("trip_off", trip_oe, 16'h0);
    chk("alm_latch", alm_oe, 16'h1);
    ara;
    chk("alm_clr", alm_oe, 16'h0);
    wreg(8'h09, 8'h80);
    temps(10'h096, 10'h019, 1'b0);
    chk("alm_mask", alm_oe, 16'h0);
    chk("trip_nomask", trip_oe, 16'h1);
    wreg(8'h09, 8'h20);
    chk("alm_trip2", alm_oe, 16'h1);
    temps(10'h019, 10'h019, 1'b0);
    chk("trip2_off", alm_oe, 16'h0);
    wreg(8'h09, 8'h00);
    ara;
    temps(10'h019, 10'h019, 1'b1);
    rchk("flag_open", 8'h02, 8'h04);
    chk("alm_open", alm_oe, 16'h1);
    temps(10'h019, 10'h019, 1'b0);
    ara;
    chk("open_clr", alm_oe, 16'h0);
    ara;
    chk("ara_nak", k, 16'h1);
    wreg(8'h09, 8'h04);
    temps(10'h019, 10'h3c9, 1'b0);
    rchk("ext_local", 8'h00, 8'h59);
    rchk("ext_remote", 8'h01, 8'h09);
    test_done;
  end
endmodule // tb
